// file: core/css_consts.svh
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
// Turn-on source encodings.
`define CSS_SRC_VIN      2'h0
`define CSS_SRC_CMD      2'h1
`define CSS_SRC_PIN      2'h2
`define CSS_SRC_CMD_PIN  2'h3
// Field positions inside the channel configuration word.
`define CSS_CFG_CONT     7
`define CSS_CFG_WARN     6
`define CSS_CFG_FASTOFF  5
`define CSS_CFG_OFFSEQ   4
`define CSS_CFG_UVOFF    3
`define CSS_CFG_OVIGN    2
`define CSS_CFG_DAC_HI   1
`define CSS_CFG_DAC_LO   0
// DAC connection modes.
`define CSS_DAC_SOFT     2'h0
`define CSS_DAC_OFF      2'h1
`define CSS_DAC_MSOFT    2'h2
`define CSS_DAC_MHARD    2'h3
// Margin selection.
`define CSS_MRG_NOM      2'h0
`define CSS_MRG_LOW      2'h1
`define CSS_MRG_HIGH     2'h2
// Fast ramp step time in ns and its cycle count at 50 MHz.
`define CSS_FAST_STEP_NS 1000
`define CSS_CLK_NS       20
`define CSS_FAST_STEP_CYC ((`CSS_FAST_STEP_NS + `CSS_CLK_NS - 1) / `CSS_CLK_NS)
// Near-target window in volt LSBs, where fast ramp hands over to slow.
`define CSS_NEAR_LSB     16'h0010
`define CSS_RESET_CFG    8'h80
`endif

// file: core/css_pkg.sv
package css_pkg;
    // Per-channel settings that travel together.
    typedef struct packed {
        logic [7:0]  cfg;
        logic [1:0]  src;
        logic [15:0] ton_delay;
        logic [15:0] ton_rise;
        logic [15:0] ton_max;
        logic [15:0] toff_delay;
        logic [15:0] vout_cmd;
        logic [15:0] mrg_high;
        logic [15:0] mrg_low;
        logic [15:0] ov_fault;
        logic [15:0] uv_fault;
        logic [15:0] ov_warn;
        logic [15:0] uv_warn;
        logic [7:0]  decay_factor;
        logic [9:0]  dac_code;
    } css_chan_cfg_s;
    // Per-channel observed state.
    typedef struct packed {
        logic       en;
        logic       on;
        logic       ov_fault;
        logic       ton_fault;
        logic       decay_hold;
        logic       connected;
        logic [9:0] dac;
    } css_chan_stat_s;
    typedef enum logic [2:0] {
        CSS_OFF, CSS_WAIT_ON, CSS_RISE, CSS_RUN, CSS_WAIT_OFF
    } css_state_e;
endpackage

// file: core/css_channel.sv
`include "css_consts.svh"
module css_channel #(
    parameter int CW = 16
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   want_on,
    input  wire logic                   vin_drop,
    input  wire logic                   tick_us,
    input  wire logic                   meas_valid,
    input  wire logic [15:0]            meas_vout,
    input  wire logic [15:0]            meas_fb,
    input  wire logic [1:0]             margin_sel,
    input  wire logic                   dac_write,
    input  wire css_pkg::css_chan_cfg_s cfg,
    output css_pkg::css_chan_stat_s     stat,
    output logic                        fault_drive
);
    css_pkg::css_state_e state_q;
    logic [CW-1:0]       cnt_q;
    logic [9:0]          dac_q;
    logic                conn_q;
    logic                settled_q;
    logic                fast_q;
    logic [15:0]         target_q;
    logic [15:0]         fstep_q;
    logic                ovf_q;
    logic                tonf_q;
    logic                hold_q;
    logic [23:0]         thresh;
    logic [1:0]          dmode;
    logic                sstep;
    logic                near;
    logic                warn_out;
    logic [15:0]         tgt_d;
    logic [15:0]         rd_q;
    logic [15:0]         vnow;

    // Absolute difference between two readings.
    function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    // Latest reading of this channel; between its slots the scan bus shows other channels.
    always_ff @(posedge ref_clk) begin
        if (rst) rd_q <= 16'h0000;
        else if (meas_valid) rd_q <= meas_vout;
    end
    assign vnow = meas_valid ? meas_vout : rd_q;

    assign dmode    = {cfg.cfg[`CSS_CFG_DAC_HI], cfg.cfg[`CSS_CFG_DAC_LO]};
    assign thresh   = cfg.vout_cmd * cfg.decay_factor;
    assign near     = absdiff(vnow, target_q) <= `CSS_NEAR_LSB;
    assign warn_out = (vnow > cfg.ov_warn) || (vnow < cfg.uv_warn);
    // Margin requests count only while connected.
    always_comb begin
        tgt_d = cfg.vout_cmd;
        if (conn_q && margin_sel == `CSS_MRG_HIGH) tgt_d = cfg.mrg_high;
        if (conn_q && margin_sel == `CSS_MRG_LOW)  tgt_d = cfg.mrg_low;
    end

    // Sequencing state machine with a microsecond delay counter.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= css_pkg::CSS_OFF;
            cnt_q   <= '0;
            tonf_q  <= 1'b0;
            hold_q  <= 1'b0;
        end else begin
            if (tick_us) cnt_q <= cnt_q + 1'b1;
            unique case (state_q)
                css_pkg::CSS_OFF: begin
                    cnt_q <= '0;
                    if (want_on && !vin_drop) begin
                        if ({8'h00, vnow} >= (thresh >> 8)) hold_q <= 1'b1;
                        else begin
                            hold_q  <= 1'b0;
                            tonf_q  <= 1'b0;
                            state_q <= css_pkg::CSS_WAIT_ON;
                        end
                    end
                end
                css_pkg::CSS_WAIT_ON: begin
                    if (!want_on || vin_drop) state_q <= css_pkg::CSS_OFF;
                    else if (cnt_q >= cfg.ton_delay[CW-1:0]) begin
                        cnt_q   <= '0;
                        state_q <= css_pkg::CSS_RISE;
                    end
                end
                css_pkg::CSS_RISE, css_pkg::CSS_RUN: begin
                    if (state_q == css_pkg::CSS_RISE && cnt_q >= cfg.ton_rise[CW-1:0])
                        state_q <= css_pkg::CSS_RUN;
                    if (cnt_q == cfg.ton_max[CW-1:0] && vnow < cfg.uv_fault) begin
                        tonf_q <= 1'b1;
                        if (cfg.cfg[`CSS_CFG_UVOFF]) state_q <= css_pkg::CSS_OFF;
                    end
                    if (vin_drop && !cfg.cfg[`CSS_CFG_OFFSEQ]) state_q <= css_pkg::CSS_OFF;
                    else if (!want_on || vin_drop) begin
                        cnt_q   <= '0;
                        state_q <= css_pkg::CSS_WAIT_OFF;
                    end
                end
                css_pkg::CSS_WAIT_OFF: begin
                    if (cnt_q >= cfg.toff_delay[CW-1:0]) state_q <= css_pkg::CSS_OFF;
                end
            endcase
        end
    end

    // Overvoltage supervision, suppressed while margining with ignore set.
    always_ff @(posedge ref_clk) begin
        if (rst) ovf_q <= 1'b0;
        else if (meas_valid && meas_vout > cfg.ov_fault
                 && !(cfg.cfg[`CSS_CFG_OVIGN] && margin_sel != `CSS_MRG_NOM))
            ovf_q <= 1'b1;
        else if (state_q == css_pkg::CSS_OFF && want_on)
            ovf_q <= 1'b0;
    end

    // Fast ramp step timer.
    always_ff @(posedge ref_clk) begin
        if (rst || fstep_q == 16'(`CSS_FAST_STEP_CYC - 1)) fstep_q <= '0;
        else fstep_q <= fstep_q + 16'h0001;
    end
    assign sstep = fast_q ? (fstep_q == 16'h0000) : meas_valid;

    // DAC connection and servo loop.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dac_q     <= 10'h000;
            conn_q    <= 1'b0;
            settled_q <= 1'b0;
            fast_q    <= 1'b0;
            target_q  <= 16'h0000;
        end else if (state_q != css_pkg::CSS_RUN || dmode == `CSS_DAC_OFF) begin
            conn_q    <= 1'b0;
            settled_q <= 1'b0;
            fast_q    <= 1'b0;
            if (dmode == `CSS_DAC_MHARD || dmode == `CSS_DAC_MSOFT) dac_q <= cfg.dac_code;
        end else if (!conn_q) begin
            target_q <= tgt_d;
            if (dmode == `CSS_DAC_MHARD) begin
                dac_q  <= cfg.dac_code;
                conn_q <= 1'b1;
            end else if (meas_valid) begin
                // Match the feedback node, close when within one step.
                if (absdiff({6'h00, dac_q}, meas_fb) <= 16'h0001) begin
                    conn_q <= 1'b1;
                    fast_q <= !cfg.cfg[`CSS_CFG_FASTOFF];
                end else if ({6'h00, dac_q} < meas_fb) dac_q <= dac_q + 10'h001;
                else dac_q <= dac_q - 10'h001;
            end
        end else if (dmode != `CSS_DAC_SOFT) begin
            if (dac_write) dac_q <= cfg.dac_code;
        end else begin
            if (tgt_d != target_q) begin
                target_q  <= tgt_d;
                settled_q <= 1'b0;
                fast_q    <= !cfg.cfg[`CSS_CFG_FASTOFF];
            end
            if (fast_q && near) fast_q <= 1'b0;
            if (meas_valid && !cfg.cfg[`CSS_CFG_CONT] && cfg.cfg[`CSS_CFG_WARN] && warn_out)
                settled_q <= 1'b0;
            if (sstep && (cfg.cfg[`CSS_CFG_CONT] || !settled_q)) begin
                if (vnow < target_q && dac_q != 10'h3ff) dac_q <= dac_q + 10'h001;
                else if (vnow > target_q && dac_q != 10'h000) dac_q <= dac_q - 10'h001;
                else if (!cfg.cfg[`CSS_CFG_CONT]) settled_q <= 1'b1;
            end
        end
    end

    assign stat.en         = (state_q == css_pkg::CSS_RISE) || (state_q == css_pkg::CSS_RUN)
                             || (state_q == css_pkg::CSS_WAIT_OFF);
    assign stat.on         = state_q == css_pkg::CSS_RUN;
    assign stat.ov_fault   = ovf_q;
    assign stat.ton_fault  = tonf_q;
    assign stat.decay_hold = hold_q;
    assign stat.connected  = conn_q;
    assign stat.dac        = dac_q;
    assign fault_drive     = tonf_q && cfg.cfg[`CSS_CFG_UVOFF];
endmodule // css_channel

// file: core/css_top.sv
`include "css_consts.svh"
module css_top #(
    parameter int NCH = 8,
    parameter int US_CYC = 50
) (
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    input  wire logic                            input_sense_pin,
    input  wire logic                            vin_off_flag,
    input  wire logic                            control_pin,
    input  wire logic [NCH-1:0]                  op_cmd_on,
    input  wire logic [NCH-1:0][1:0]             op_margin,
    input  wire logic [NCH-1:0]                  dac_write,
    input  wire css_pkg::css_chan_cfg_s [NCH-1:0] chan_cfg,
    input  wire logic                            meas_valid,
    input  wire logic [2:0]                      meas_chan,
    input  wire logic [15:0]                     meas_vout,
    input  wire logic [15:0]                     meas_fb,
    input  wire logic                            shared_fault_line_n_in,
    output logic                                 shared_fault_line_n_out,
    output logic                                 shared_fault_line_n_oe,
    output logic                                 alert_line_n,
    output logic [NCH-1:0]                       vout_enable,
    output logic [NCH-1:0][9:0]                  trim_dac_out,
    output logic [NCH-1:0]                       trim_dac_oe,
    output css_pkg::css_chan_stat_s [NCH-1:0]    chan_stat
);
    logic                 vin_s1_q, vin_s2_q, off_s1_q, off_s2_q, ctl_s1_q, ctl_s2_q;
    logic                 flt_s1_q, flt_s2_q;
    logic                 vin_ok_q;
    logic [7:0]           us_q;
    logic                 tick;
    logic [NCH-1:0]       want;
    logic [NCH-1:0]       fdrv;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    always_ff @(posedge ref_clk) begin
        vin_s1_q <= input_sense_pin;
        vin_s2_q <= vin_s1_q;
        off_s1_q <= vin_off_flag;
        off_s2_q <= off_s1_q;
        ctl_s1_q <= control_pin;
        ctl_s2_q <= ctl_s1_q;
        flt_s1_q <= shared_fault_line_n_in;
        flt_s2_q <= flt_s1_q;
    end

    // Input qualification: on above the on threshold, off below the off one.
    always_ff @(posedge ref_clk) begin
        if (rst) vin_ok_q <= 1'b0;
        else if (off_s2_q) vin_ok_q <= 1'b0;
        else if (vin_s2_q) vin_ok_q <= 1'b1;
    end

    // Microsecond tick for delay counters.
    always_ff @(posedge ref_clk) begin
        if (rst || us_q == 8'(US_CYC - 1)) us_q <= 8'h00;
        else us_q <= us_q + 8'h01;
    end
    assign tick = us_q == 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel instances sharing one scan.
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        always_comb begin
            unique case (chan_cfg[i].src)
                `CSS_SRC_VIN:     want[i] = vin_ok_q;
                `CSS_SRC_CMD:     want[i] = vin_ok_q && op_cmd_on[i];
                `CSS_SRC_PIN:     want[i] = vin_ok_q && ctl_s2_q;
                `CSS_SRC_CMD_PIN: want[i] = vin_ok_q && op_cmd_on[i] && ctl_s2_q;
            endcase
        end
        css_channel u_ch (
            .ref_clk     (ref_clk),
            .rst         (rst),
            .want_on     (want[i] && flt_s2_q),
            .vin_drop    (!vin_ok_q),
            .tick_us     (tick),
            .meas_valid  (meas_valid && meas_chan == 3'(i)),
            .meas_vout   (meas_vout),
            .meas_fb     (meas_fb),
            .margin_sel  (op_margin[i]),
            .dac_write   (dac_write[i]),
            .cfg         (chan_cfg[i]),
            .stat        (chan_stat[i]),
            .fault_drive (fdrv[i])
        );
        assign vout_enable[i]  = chan_stat[i].en;
        assign trim_dac_out[i] = chan_stat[i].dac;
        assign trim_dac_oe[i]  = chan_stat[i].connected;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault line and alert output.
    always_comb begin
        alert_line_n = 1'b1;
        for (int k = 0; k < NCH; k++) begin
            if (chan_stat[k].decay_hold || chan_stat[k].ov_fault || chan_stat[k].ton_fault)
                alert_line_n = 1'b0;
        end
    end
    assign shared_fault_line_n_out = 1'b0;
    assign shared_fault_line_n_oe  = |fdrv;
endmodule // css_top

// file: tb/css_conv_model.sv
module css_conv_model #(
    parameter int NCH = 2
) (
    input  wire logic           ref_clk,
    input  wire logic           rst,
    input  wire logic [NCH-1:0] vout_enable,
    output logic                meas_valid,
    output logic [2:0]          meas_chan,
    output logic [15:0]         meas_vout,
    output logic [15:0]         meas_fb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  slot_q;
    logic [2:0]  chan_q;
    logic [15:0] vout_q [NCH];
    // One reading every four cycles, channels in turn; outputs rise while enabled, decay slowly.
    always_ff @(posedge ref_clk) begin
        slot_q <= rst ? 2'h0 : slot_q + 2'h1;
        meas_valid <= !rst && slot_q == 2'h3;
        if (rst) begin
            chan_q <= 3'h0;
            meas_chan <= 3'h0;
            for (int i = 0; i < NCH; i++) vout_q[i] <= 16'h0;
        end else if (slot_q == 2'h3) begin
            meas_chan <= chan_q;
            chan_q <= (chan_q == 3'(NCH - 1)) ? 3'h0 : chan_q + 3'h1;
            if (vout_enable[chan_q])
                vout_q[chan_q] <= (vout_q[chan_q] >= 16'h0e00) ? 16'h1000 : vout_q[chan_q] + 16'h0200;
            else
                vout_q[chan_q] <= (vout_q[chan_q] < 16'h0100) ? 16'h0 : vout_q[chan_q] - 16'h0100;
        end
    end
    // Between readings the scan bus carries inverted junk, not the last value.
    assign meas_vout = meas_valid ? vout_q[meas_chan] : ~vout_q[meas_chan];
    assign meas_fb   = meas_valid ? 16'h0080 : 16'hff7f;
endmodule // css_conv_model

// file: tb/css_top_assertions.sv
`include "css_consts.svh"
module css_top_assertions #(
    parameter int NCH = 8
) (
    input wire logic                              ref_clk,
    input wire logic                              rst,
    input wire logic                              input_sense_pin,
    input wire logic                              vin_off_flag,
    input wire css_pkg::css_chan_cfg_s [NCH-1:0]  chan_cfg,
    input wire logic                              alert_line_n,
    input wire logic [NCH-1:0]                    vout_enable,
    input wire logic [NCH-1:0]                    trim_dac_oe,
    input wire css_pkg::css_chan_stat_s [NCH-1:0] chan_stat
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] low_q;
    logic       any_flag;
    // Counts cycles with the input below its on level, saturating.
    always_ff @(posedge ref_clk) begin
        if (rst || input_sense_pin) low_q <= 4'h0;
        else if (low_q != 4'hf) low_q <= low_q + 4'h1;
    end
    // Gathers every flag that should pull the alert line.
    always_comb begin
        any_flag = 1'b0;
        for (int i = 0; i < NCH; i++)
            any_flag |= chan_stat[i].decay_hold | chan_stat[i].ov_fault | chan_stat[i].ton_fault;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_vin_drop;
        (vin_off_flag && !chan_cfg[0].cfg[`CSS_CFG_OFFSEQ]) [*5];
    endsequence
    sequence s_dac_float;
        (chan_cfg[0].cfg[1:0] == `CSS_DAC_OFF) [*2];
    endsequence
    a_reset_quiet: assert property ($fell(rst) |-> vout_enable == '0 && alert_line_n)
        else $error("outputs active after reset");
    a_vin_gate: assert property ($rose(vout_enable[0]) |-> low_q < 4'h4)
        else $error("enable rose with input low");
    a_vin_drop: assert property (s_vin_drop |-> !vout_enable[0])
        else $error("enable held after input drop");
    a_alert_flags: assert property (alert_line_n == !any_flag)
        else $error("alert line disagrees with flags");
    a_enable_stat: assert property (vout_enable[0] == chan_stat[0].en)
        else $error("enable and status differ");
    a_dac_float: assert property (s_dac_float |-> !trim_dac_oe[0] && !chan_stat[0].connected)
        else $error("dac driven in disconnected mode");
    a_soft_wait: assert property ($rose(trim_dac_oe[0]) && chan_cfg[0].cfg[1:0] == `CSS_DAC_SOFT
        |-> $past(vout_enable[0], 6))
        else $error("soft connect before rise time");
    a_oe_stat: assert property (trim_dac_oe[0] == chan_stat[0].connected)
        else $error("dac enable and status differ");
endmodule // css_top_assertions
bind css_top css_top_assertions #(.NCH(NCH)) u_css_top_assertions (
    .ref_clk(ref_clk), .rst(rst), .input_sense_pin(input_sense_pin), .vin_off_flag(vin_off_flag),
    .chan_cfg(chan_cfg), .alert_line_n(alert_line_n), .vout_enable(vout_enable),
    .trim_dac_oe(trim_dac_oe), .chan_stat(chan_stat));

// file: tb/channel_sequence_servo_control_test.sv
`include "css_consts.svh"
module channel_sequence_servo_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCH = 2;
    localparam logic [7:0] SRC_EXP = 8'h35;
    logic                             ref_clk, rst, input_sense_pin, vin_off_flag, control_pin;
    logic                             meas_valid, flt_out, flt_oe, flt_wire, alert_line_n;
    logic [NCH-1:0]                   op_cmd_on, dac_write, vout_enable, trim_dac_oe;
    logic [NCH-1:0][1:0]              op_margin;
    logic [NCH-1:0][9:0]              trim_dac_out;
    logic [2:0]                       meas_chan;
    logic [15:0]                      meas_vout, meas_fb;
    css_pkg::css_chan_cfg_s [NCH-1:0]  chan_cfg;
    css_pkg::css_chan_stat_s [NCH-1:0] chan_stat;
    int                               mismatches, comparisons, n;
    ////////////////////////////////
    // Open-drain fault line with a pull-up.
    assign flt_wire = (flt_oe && !flt_out) ? 1'b0 : 1'b1;
    css_top #(.NCH(NCH), .US_CYC(2)) u_css_top (.ref_clk(ref_clk), .rst(rst),
        .input_sense_pin(input_sense_pin), .vin_off_flag(vin_off_flag), .control_pin(control_pin),
        .op_cmd_on(op_cmd_on), .op_margin(op_margin), .dac_write(dac_write), .chan_cfg(chan_cfg),
        .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_vout(meas_vout), .meas_fb(meas_fb),
        .shared_fault_line_n_in(flt_wire), .shared_fault_line_n_out(flt_out),
        .shared_fault_line_n_oe(flt_oe), .alert_line_n(alert_line_n), .vout_enable(vout_enable),
        .trim_dac_out(trim_dac_out), .trim_dac_oe(trim_dac_oe), .chan_stat(chan_stat));
    css_conv_model #(.NCH(NCH)) u_css_conv_model (.ref_clk(ref_clk), .rst(rst),
        .vout_enable(vout_enable), .meas_valid(meas_valid), .meas_chan(meas_chan),
        .meas_vout(meas_vout), .meas_fb(meas_fb));
    ////////////////////////////////
    // Free-running 50 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return vout_enable[0];
            1: return trim_dac_oe[0];
            default: return chan_stat[0].decay_hold;
        endcase
    endfunction
    // Waits for a watched output to reach a level; a spent bound ends the run.
    task automatic wait_for(input int sel, input logic lvl, input int lim);
        for (n = 0; n < lim; n++) begin
            @(posedge ref_clk);
            #1;
            if (pick(sel) === lvl) return;
        end
        mismatches++;
        print_verdict();
    endtask
    function automatic css_pkg::css_chan_cfg_s base_cfg();
        css_pkg::css_chan_cfg_s c;
        c = '0;
        c.cfg = `CSS_RESET_CFG;
        c.src = `CSS_SRC_CMD_PIN;
        c.ton_delay = 16'h0005;
        c.ton_rise = 16'h0004;
        c.ton_max = 16'h0100;
        c.toff_delay = 16'h0003;
        c.vout_cmd = 16'h1000;
        c.mrg_high = 16'h1100;
        c.mrg_low = 16'h0f00;
        c.ov_fault = 16'hffff;
        c.ov_warn = 16'hffff;
        c.decay_factor = 8'h40;
        c.dac_code = 10'h155;
        return c;
    endfunction
    task automatic restart(input logic [1:0] mode);
        @(posedge ref_clk);
        op_cmd_on[0] <= 1'b0;
        repeat (300) @(posedge ref_clk);
        chan_cfg[0].cfg[1:0] <= mode;
        op_cmd_on[0] <= 1'b1;
        wait_for(0, 1'b1, 100);
    endtask
    ////////////////////////////////
    task automatic t_vin_gate();
        @(posedge ref_clk);
        op_cmd_on[0] <= 1'b1;
        control_pin <= 1'b1;
        repeat (60) @(posedge ref_clk);
        #1 check(vout_enable, '0);
        @(posedge ref_clk);
        op_cmd_on[0] <= 1'b0;
        control_pin <= 1'b0;
    endtask
    task automatic t_sources();
        input_sense_pin <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            chan_cfg[1].src <= k[1:0];
            op_cmd_on[1] <= k[2];
            control_pin <= ~k[2];
            repeat (40) @(posedge ref_clk);
            #1 check(vout_enable[1], SRC_EXP[k]);
            @(posedge ref_clk);
            chan_cfg[1].src <= `CSS_SRC_CMD;
            op_cmd_on[1] <= 1'b0;
            repeat (200) @(posedge ref_clk);
        end
    endtask
    task automatic t_on_soft_off();
        @(posedge ref_clk);
        control_pin <= 1'b1;
        op_cmd_on[0] <= 1'b1;
        wait_for(0, 1'b1, 40);
        check(n >= 9 && n <= 18, 1'b1);
        wait_for(1, 1'b1, 1200);
        check(n >= 6, 1'b1);
        check(trim_dac_out[0] >= 10'h07f && trim_dac_out[0] <= 10'h081, 1'b1);
        @(posedge ref_clk);
        op_margin[0] <= `CSS_MRG_HIGH;
        repeat (200) @(posedge ref_clk);
        #1 check(trim_dac_out[0] >= 10'h082, 1'b1);
        @(posedge ref_clk);
        op_margin[0] <= `CSS_MRG_NOM;
        op_cmd_on[0] <= 1'b0;
        wait_for(0, 1'b0, 40);
        check(n >= 5 && n <= 12, 1'b1);
    endtask
    task automatic t_decay();
        @(posedge ref_clk);
        op_cmd_on[0] <= 1'b1;
        wait_for(2, 1'b1, 40);
        check({alert_line_n, vout_enable[0]}, 2'h0);
        wait_for(0, 1'b1, 400);
        check(n >= 70, 1'b1);
    endtask
    task automatic t_hard();
        restart(`CSS_DAC_MHARD);
        wait_for(1, 1'b1, 100);
        check(trim_dac_out[0], 10'h155);
        @(posedge ref_clk);
        chan_cfg[0].dac_code <= 10'h0aa;
        dac_write[0] <= 1'b1;
        @(posedge ref_clk);
        dac_write[0] <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 check(trim_dac_out[0], 10'h0aa);
    endtask
    task automatic t_dac_off_drop();
        restart(`CSS_DAC_OFF);
        @(posedge ref_clk);
        op_margin[0] <= `CSS_MRG_HIGH;
        repeat (60) @(posedge ref_clk);
        #1 check({trim_dac_oe[0], chan_stat[0].connected}, 2'h0);
        @(posedge ref_clk);
        vin_off_flag <= 1'b1;
        wait_for(0, 1'b0, 8);
        check(vout_enable, '0);
    endtask
    // Main sequence: reset, then each scenario in turn.
    initial begin
        rst = 1'b1;
        {input_sense_pin, vin_off_flag, control_pin, op_cmd_on, op_margin, dac_write} = '0;
        chan_cfg = {base_cfg(), base_cfg()};
        mismatches = 0;
        comparisons = 0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 check({vout_enable, trim_dac_oe, alert_line_n}, 16'h0001);
        t_vin_gate();
        t_sources();
        t_on_soft_off();
        t_decay();
        t_hard();
        t_dac_off_drop();
        print_verdict();
    end
endmodule // channel_sequence_servo_control_test
